// ---- core/pifrc_core.sv ----
/*
  Peripheral event flag register, reset cause register, enable masks
  and one level interrupt, reached over a classic Wishbone slave.
  Assumes event strobes are synchronous to clk_i, pins are asynchronous,
  and the surrounding reset logic reports which kind of reset fired.
*/
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps

module pifrc_core
  import pifrc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_i,
  input wire logic external_reset_pin_n_i,
  input wire logic watchdog_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic conv_overflow_i,
  input wire logic conv_capture_i,
  input wire logic [3:0] port_c_hi_i,
  input wire logic serial_done_i,
  input wire logic oscillator_button_pin_i,
  input wire logic comparator_out_i,
  input wire logic low_voltage_detect_i,
  output logic device_reset_o,
  output logic [7:0] event_enable_o,
  output logic global_irq_enable_o,
  output logic external_crystal_mode_o,
  output logic irq_o
);

  pifrc_byte_t peripheral_event_flags;
  pifrc_byte_t reset_cause_flags;
  pifrc_byte_t event_mask;
  pifrc_byte_t irq_status;
  pifrc_byte_t irq_mask;
  pifrc_byte_t control;
  pifrc_byte_t next_event_flags;
  pifrc_byte_t next_cause_flags;
  pifrc_byte_t event_set;
  pifrc_byte_t read_data;
  pifrc_reset_kind_t reset_kind;
  logic [3:0] port_meta;
  logic [3:0] port_sync;
  logic [3:0] port_prev;
  logic [1:0] button_meta;
  logic [1:0] button_sync;
  logic button_prev;
  logic cmp_meta;
  logic cmp_sync;
  logic lvd_meta;
  logic lvd_sync;
  logic external_reset_pin_meta;
  logic external_reset_pin_sync_n;
  logic port_primed;
  logic wr_stb;
  logic rd_hit;

  function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] ofs);
    addr_is = (adr == ofs);
  endfunction

  function automatic pifrc_byte_t bit_at(input int pos);
    bit_at = pifrc_byte_t'(1) << pos;
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    port_meta <= port_c_hi_i;
    port_sync <= port_meta;
    button_meta <= {button_meta[0], oscillator_button_pin_i};
    button_sync <= {button_sync[0], button_meta[1]};
    cmp_meta <= comparator_out_i;
    cmp_sync <= cmp_meta;
    lvd_meta <= low_voltage_detect_i;
    lvd_sync <= lvd_meta;
    external_reset_pin_meta <= external_reset_pin_n_i;
    external_reset_pin_sync_n <= external_reset_pin_meta;
  end

  // Edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_prev <= 4'h0;
      button_prev <= 1'b1;
      port_primed <= 1'b0;
    end else begin
      port_prev <= port_sync;
      button_prev <= button_sync[1];
      port_primed <= 1'b1;
    end
  end

  // External reset pin drives device reset
  assign device_reset_o = ~external_reset_pin_sync_n | power_on_reset_i;

  always_comb begin
    if (power_on_reset_i) begin
      reset_kind = PIFRC_RST_POWER;
    end else if (!external_reset_pin_sync_n) begin
      reset_kind = PIFRC_RST_EXTERNAL;
    end else if (watchdog_reset_i) begin
      reset_kind = PIFRC_RST_WATCHDOG;
    end else begin
      reset_kind = PIFRC_RST_NONE;
    end
  end

  // Event detection, independent of the enable masks; crystal mode blocks the button event
  always_comb begin
    event_set = `PIFRC_ZERO8;
    event_set[`PIFRC_BIT_OVF] = conv_overflow_i;
    event_set[`PIFRC_BIT_CAP] = conv_capture_i;
    event_set[`PIFRC_BIT_PORT] = port_primed && (port_sync != port_prev);
    event_set[`PIFRC_BIT_SER] = serial_done_i;
    event_set[`PIFRC_BIT_BTN] = !control[`PIFRC_BIT_XTAL] && button_prev && !button_sync[1];
    event_set[`PIFRC_BIT_CMP] = cmp_sync;
  end

  // Write lands at the edge where the master samples ack
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i && wb_ack_o;

  // Write clears or loads, then set wins
  always_comb begin
    next_event_flags = peripheral_event_flags;
    if (wr_stb && addr_is(wb_adr_i, `PIFRC_OFS_EVENT_FLAGS)) begin
      next_event_flags = wb_dat_i;
    end
    next_event_flags = (next_event_flags | event_set) & `PIFRC_EVENT_IMPL;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peripheral_event_flags <= `PIFRC_EVENT_RST;
    end else begin
      peripheral_event_flags <= next_event_flags;
    end
  end

  // Reset cause flags
  always_comb begin
    next_cause_flags = reset_cause_flags;
    if (wr_stb && addr_is(wb_adr_i, `PIFRC_OFS_CAUSE_FLAGS)) begin
      next_cause_flags = wb_dat_i & `PIFRC_CAUSE_WMASK;
    end
    if (lvd_sync) begin
      next_cause_flags[`PIFRC_BIT_LVD] = 1'b0;
    end
    next_cause_flags[`PIFRC_BIT_RSVD] = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (reset_kind == PIFRC_RST_POWER) begin
      reset_cause_flags <= `PIFRC_ZERO8;
    end else begin
      reset_cause_flags <= next_cause_flags;
    end
  end

  // Enable, mask and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_mask <= `PIFRC_ZERO8;
      irq_mask <= `PIFRC_ZERO8;
      control <= `PIFRC_ZERO8;
    end else if (wr_stb) begin
      if (addr_is(wb_adr_i, `PIFRC_OFS_EVENT_MASK)) begin
        event_mask <= wb_dat_i & `PIFRC_EVENT_IMPL;
      end
      if (addr_is(wb_adr_i, `PIFRC_OFS_IRQ_MASK)) begin
        irq_mask <= wb_dat_i & `PIFRC_EVENT_IMPL;
      end
      if (addr_is(wb_adr_i, `PIFRC_OFS_CONTROL)) begin
        control <= wb_dat_i & (bit_at(`PIFRC_BIT_GIE) | bit_at(`PIFRC_BIT_XTAL));
      end
    end
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= `PIFRC_ZERO8;
    end else if (wr_stb && addr_is(wb_adr_i, `PIFRC_OFS_IRQ_STATUS)) begin
      irq_status <= (irq_status & ~wb_dat_i) | event_set;
    end else begin
      irq_status <= irq_status | event_set;
    end
  end

  assign event_enable_o = event_mask;
  assign global_irq_enable_o = control[`PIFRC_BIT_GIE];
  assign external_crystal_mode_o = control[`PIFRC_BIT_XTAL];

  // Comparator level holds the flag while high
  assign irq_o = |(irq_status & irq_mask) | (cmp_sync & irq_mask[`PIFRC_BIT_CMP]);

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    read_data = `PIFRC_ZERO8;
    case (wb_adr_i)
      `PIFRC_OFS_EVENT_FLAGS: read_data = peripheral_event_flags & `PIFRC_EVENT_IMPL;
      `PIFRC_OFS_CAUSE_FLAGS: read_data = reset_cause_flags & `PIFRC_CAUSE_WMASK;
      `PIFRC_OFS_EVENT_MASK: read_data = event_mask;
      `PIFRC_OFS_IRQ_STATUS: read_data = irq_status;
      `PIFRC_OFS_IRQ_MASK: read_data = irq_mask;
      `PIFRC_OFS_CONTROL: read_data = control;
      default: rd_hit = 1'b0;
    endcase
  end

  // Wishbone answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `PIFRC_ZERO8;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (rd_hit && wb_cyc_i && wb_stb_i && !wb_we_i) ? read_data : `PIFRC_ZERO8;
    end
  end

endmodule // pifrc_core

// ---- core/pifrc_map.svh ----
/*
  Register offsets, field positions and reset values of the peripheral
  event flag and reset cause block.
  Assumes inclusion by bare name from the package; the core module uses its macros without an include.
*/
`ifndef PIFRC_MAP_SVH
`define PIFRC_MAP_SVH

`define PIFRC_OFS_EVENT_FLAGS 8'h0c
`define PIFRC_OFS_CAUSE_FLAGS 8'h8e
`define PIFRC_OFS_EVENT_MASK 8'h8c
`define PIFRC_OFS_IRQ_STATUS 8'h90
`define PIFRC_OFS_IRQ_MASK 8'h91
`define PIFRC_OFS_CONTROL 8'h92

`define PIFRC_BIT_OVF 0
`define PIFRC_BIT_CAP 1
`define PIFRC_BIT_PORT 2
`define PIFRC_BIT_SER 3
`define PIFRC_BIT_BTN 4
`define PIFRC_BIT_CMP 7
`define PIFRC_EVENT_IMPL 8'h9f

`define PIFRC_BIT_LVD 0
`define PIFRC_BIT_POR 1
`define PIFRC_BIT_RSVD 7
`define PIFRC_CAUSE_WMASK 8'h83

`define PIFRC_BIT_GIE 0
`define PIFRC_BIT_XTAL 1

`define PIFRC_EVENT_RST 8'h00
`define PIFRC_ZERO8 8'h00
`define PIFRC_WB_ADDR_W 8

`endif

// ---- core/pifrc_pkg.sv ----
/*
  Types of the peripheral event flag and reset cause block.
  Assumes the constant map header is on the include path.
*/
`include "pifrc_map.svh"

package pifrc_pkg;
  typedef logic [7:0] pifrc_byte_t;
  typedef enum logic [1:0] {
    PIFRC_RST_NONE,
    PIFRC_RST_POWER,
    PIFRC_RST_EXTERNAL,
    PIFRC_RST_WATCHDOG
  } pifrc_reset_kind_t;
endpackage

// ---- dv/pifrc_chk_sva.sv ----
/* Port checker for pifrc_core: bus answer, read-only bits, reset paths, interrupt.
   Assumes the single clock clk_i and the synchronous reset rst_i. */
`timescale 1ns/10ps
module pifrc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic power_on_reset_i,
  input wire logic external_reset_pin_n_i,
  input wire logic device_reset_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_gap_bits: assert property (wb_ack_o && wb_adr_i == 8'h0c |-> wb_dat_o[6:5] == 2'h0)
    else $error("gap bits set");
  a_cause_top: assert property (wb_ack_o && wb_adr_i == 8'h8e |-> wb_dat_o[7:2] == 6'h00)
    else $error("cause top bits set");
  a_pin_reset: assert property (!external_reset_pin_n_i [*3] |-> device_reset_o)
    else $error("pin reset missing");
  a_power_reset: assert property (power_on_reset_i |-> device_reset_o) else $error("power reset missing");
  a_irq_release: assert property ($fell(rst_i) |-> !irq_o) else $error("irq after reset");
  a_irq_masked: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h91 && wb_dat_i == 8'h00 |=> !irq_o)
    else $error("irq while masked");
endmodule // pifrc_chk

bind pifrc_core pifrc_chk i_chk (.*);

// ---- dv/pifrc_periph.sv ----
/* Peripheral event sources: converter, serial, port pins, button, comparator.
   Assumes one command per cycle on cmd_i, zero for idle. */
`timescale 1ns/10ps
module pifrc_periph (
  input wire logic clk_i,
  input wire logic [2:0] cmd_i,
  output logic ovf_o,
  output logic cap_o,
  output logic ser_o,
  output logic [3:0] port_o = 4'h0,
  output logic btn_o = 1'h1,
  output logic cmp_o = 1'h0
);
  always_ff @(posedge clk_i) begin
    ovf_o <= cmd_i == 3'h1;
    cap_o <= cmd_i == 3'h2;
    ser_o <= cmd_i == 3'h3;
    if (cmd_i == 3'h4) port_o <= ~port_o;
    if (cmd_i == 3'h5) btn_o <= ~btn_o;
    if (cmd_i == 3'h6) cmp_o <= ~cmp_o;
  end
endmodule // pifrc_periph

// ---- dv/test_pifrc_core.sv ----
/* Self-checking bench for pifrc_core over classic Wishbone.
   Assumes the core, the event model and the checker compile first. */
`timescale 1ns/10ps
module test_pifrc_core;
  logic clk_i = 1'h0, rst_i = 1'h1, power_on_reset_i = 1'h1, external_reset_pin_n_i = 1'h1;
  logic watchdog_reset_i = 1'h0, low_voltage_detect_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, wb_sel_i = 1'h1, wb_ack_o, device_reset_o, global_irq_enable_o;
  logic external_crystal_mode_o, irq_o, ovf, cap, ser, btn, cmp;
  logic [7:0] wb_adr_i = 8'h00, wb_dat_i = 8'h00, wb_dat_o, event_enable_o, q;
  logic [3:0] prt;
  logic [2:0] cmd = 3'h0;
  int num_errors = 0, n_checks = 0;
  pifrc_core i_dut (.*, .conv_overflow_i(ovf), .conv_capture_i(cap), .port_c_hi_i(prt), .serial_done_i(ser),
    .oscillator_button_pin_i(btn), .comparator_out_i(cmp));
  pifrc_periph i_src (.clk_i(clk_i), .cmd_i(cmd), .ovf_o(ovf), .cap_o(cap), .ser_o(ser), .port_o(prt),
    .btn_o(btn), .cmp_o(cmp));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    acc(1'h0, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask
  task automatic ev(input logic [2:0] c);
    @(posedge clk_i);
    cmd <= c;
    @(posedge clk_i);
    cmd <= 3'h0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    wait_n(12);
    rst_i <= 1'h0;
    power_on_reset_i <= 1'h0;
    wait_n(4);
    rc(8'h0c, 8'h00);
    rc(8'h8e, 8'h00);
    acc(1'h1, 8'h8e, 8'hff);
    rc(8'h8e, 8'h03);
    watchdog_reset_i <= 1'h1;
    external_reset_pin_n_i <= 1'h0;
    wait_n(4);
    chk("dev reset", {7'h00, device_reset_o}, 8'h01);
    watchdog_reset_i <= 1'h0;
    external_reset_pin_n_i <= 1'h1;
    wait_n(4);
    rc(8'h8e, 8'h03);
    low_voltage_detect_i <= 1'h1;
    wait_n(4);
    low_voltage_detect_i <= 1'h0;
    rc(8'h8e, 8'h02);
    power_on_reset_i <= 1'h1;
    wait_n(1);
    power_on_reset_i <= 1'h0;
    rc(8'h8e, 8'h00);
    $display("test 1 done");
    for (int c = 1; c < 7; c++) ev(3'(c));
    wait_n(6);
    rc(8'h0c, 8'h9f);
    ev(3'h6);
    wait_n(4);
    acc(1'h1, 8'h0c, 8'h60);
    rc(8'h0c, 8'h00);
    rc(8'h55, 8'h00);
    acc(1'h1, 8'h8c, 8'hff);
    rc(8'h8c, 8'h9f);
    chk("enable", event_enable_o, 8'h9f);
    acc(1'h1, 8'h8c, 8'h00);
    acc(1'h1, 8'h92, 8'h01);
    chk("global", {7'h00, global_irq_enable_o}, 8'h01);
    $display("test 2 done");
    fork
      ev(3'h1);
      acc(1'h1, 8'h0c, 8'h00);
    join
    rc(8'h0c, 8'h01);
    acc(1'h1, 8'h92, 8'h02);
    chk("crystal", {7'h00, external_crystal_mode_o}, 8'h01);
    acc(1'h1, 8'h0c, 8'h00);
    ev(3'h5);
    ev(3'h5);
    wait_n(6);
    rc(8'h0c, 8'h00);
    acc(1'h1, 8'h92, 8'h00);
    $display("test 3 done");
    acc(1'h1, 8'h90, 8'hff);
    acc(1'h1, 8'h91, 8'h01);
    ev(3'h1);
    wait_n(3);
    chk("irq", {7'h00, irq_o}, 8'h01);
    acc(1'h1, 8'h91, 8'h00);
    chk("irq", {7'h00, irq_o}, 8'h00);
    acc(1'h1, 8'h91, 8'h01);
    chk("irq", {7'h00, irq_o}, 8'h01);
    acc(1'h1, 8'h90, 8'h01);
    chk("irq", {7'h00, irq_o}, 8'h00);
    $display("test 4 done");
    stop_test();
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule // test_pifrc_core
